/* design/epc_ctrl.sv */
/*
 * EEPROM program/erase controller with an AXI4-Lite register slave.
 * Assumes a single 100 MHz clock, a synchronous active-low reset fed by every
 * reset source, and a stop-mode level arriving from another domain.
 */
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
module epc_ctrl import epc_pkg::*; #(
   parameter int P_PGM_CYC = PGM_CYC,
   parameter int P_BYTE_CYC = BYTE_ERASE_CYC,
   parameter int P_BLOCK_CYC = BLOCK_ERASE_CYC,
   parameter int P_BULK_CYC = BULK_ERASE_CYC
) (
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   input wire logic [11:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [11:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   input wire logic i_stop_mode,
   output logic o_pump_on,
   output logic o_array_hv,
   output logic o_rc_osc_on
);
   //*******************************************************
   // Elaboration checks
   //*******************************************************
   if (P_PGM_CYC < 2 || P_BYTE_CYC < 2 || P_BLOCK_CYC < 2 || P_BULK_CYC < 2) begin : g_chk
      $error("epc_ctrl: pulse counts must be at least 2");
   end

   typedef enum {ENG_IDLE, ENG_PULSE, ENG_RDOLD, ENG_PROG, ENG_SWEEP, ENG_HOLD} epc_state_t;

   //*******************************************************
   // Bus and register state
   //*******************************************************
   logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
   logic [11:0] aw_addr_r, aw_addr_nxt;
   logic [7:0] w_data_r, w_data_nxt;
   logic w_strb_r, w_strb_nxt;
   logic awready_r, awready_nxt, wready_r, wready_nxt;
   logic bvalid_r, bvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   logic arready_r, arready_nxt, rd_pend_r, rd_pend_nxt, rd_inh_r, rd_inh_nxt;
   logic [11:0] rd_addr_r, rd_addr_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic [1:0] rresp_r, rresp_nxt;
   logic [7:0] ctl_r, ctl_nxt;
   logic latched_r, latched_nxt, done_r, done_nxt;
   logic [7:0] lat_addr_r, lat_addr_nxt, lat_data_r, lat_data_nxt;
   logic pump_on_r, pump_on_nxt, hv_r, hv_nxt, rc_on_r, rc_on_nxt;
   logic stop_s1_r, stop_s2_r;

   //*******************************************************
   // Engine state
   //*******************************************************
   epc_state_t st_r, st_nxt;
   logic [31:0] cnt_r, cnt_nxt, need_r, need_nxt;
   epc_erase_t mode_r, mode_nxt;
   logic [7:0] sw_addr_r, sw_addr_nxt, sw_last_r, sw_last_nxt;
   logic eng_done_r, eng_done_nxt;
   logic mem_we;
   logic [7:0] mem_waddr, mem_wdata, mem_raddr, mem_q;

   epc_mem #(.DATA_W(8), .DEPTH(ARRAY_BYTES)) u_mem (
      .i_sys_clk(i_sys_clk),
      .i_we(mem_we),
      .i_waddr(mem_waddr),
      .i_wdata(mem_wdata),
      .i_raddr(mem_raddr),
      .o_rdata(mem_q)
   );

   //*******************************************************
   // Register slave
   //*******************************************************
   always_comb begin
      aw_full_nxt = aw_full_r;
      aw_addr_nxt = aw_addr_r;
      w_full_nxt = w_full_r;
      w_data_nxt = w_data_r;
      w_strb_nxt = w_strb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      rd_pend_nxt = rd_pend_r;
      rd_addr_nxt = rd_addr_r;
      rd_inh_nxt = rd_inh_r;
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      ctl_nxt = ctl_r;
      latched_nxt = latched_r;
      lat_addr_nxt = lat_addr_r;
      lat_data_nxt = lat_data_r;
      done_nxt = done_r;
      if (i_awvalid && awready_r) begin
         aw_full_nxt = 1'b1;
         aw_addr_nxt = i_awaddr;
      end
      if (i_wvalid && wready_r) begin
         w_full_nxt = 1'b1;
         w_data_nxt = i_wdata[7:0];
         w_strb_nxt = i_wstrb[0];
      end
      if (bvalid_r && i_bready) begin
         bvalid_nxt = 1'b0;
      end
      if (aw_full_r && w_full_r && !bvalid_r) begin
         aw_full_nxt = 1'b0;
         w_full_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = RESP_OKAY;
         if (aw_addr_r[11:10] == ARR_SEL) begin
            if (ctl_r[CTL_LAT] && w_strb_r) begin
               latched_nxt = 1'b1;
               lat_addr_nxt = aw_addr_r[9:2];
               lat_data_nxt = w_data_r;
            end
         end else if (aw_addr_r == CTRL_OFS) begin
            if (w_strb_r) begin
               ctl_nxt = w_data_r & CTRL_MASK;
               // Power bit moves only while latch is already set
               if (!ctl_r[CTL_LAT]) begin
                  ctl_nxt[CTL_PWR] = ctl_r[CTL_PWR];
               end
            end
         end else if (aw_addr_r == STAT_OFS) begin
            if (w_strb_r && w_data_r[ST_DONE]) begin
               done_nxt = 1'b0;
            end
         end else begin
            bresp_nxt = RESP_SLVERR;
         end
      end
      // Hardware set beats a software clear in the same cycle
      if (eng_done_r) begin
         done_nxt = 1'b1;
      end
      if (!ctl_nxt[CTL_LAT]) begin
         latched_nxt = 1'b0;
      end
      if (rvalid_r && i_rready) begin
         rvalid_nxt = 1'b0;
      end
      if (rd_pend_r) begin
         rd_pend_nxt = 1'b0;
         rvalid_nxt = 1'b1;
         rresp_nxt = RESP_OKAY;
         if (rd_addr_r[11:10] == ARR_SEL) begin
            rdata_nxt = rd_inh_r ? INHIBIT_DATA : mem_q;
         end else if (rd_addr_r == CTRL_OFS) begin
            rdata_nxt = ctl_r;
         end else if (rd_addr_r == STAT_OFS) begin
            rdata_nxt = 8'h00;
            rdata_nxt[ST_LATCHED] = latched_r;
            rdata_nxt[ST_BUSY] = (st_r != ENG_IDLE);
            rdata_nxt[ST_DONE] = done_r;
         end else begin
            rdata_nxt = 8'h00;
            rresp_nxt = RESP_SLVERR;
         end
      end
      if (i_arvalid && arready_r) begin
         rd_pend_nxt = 1'b1;
         rd_addr_nxt = i_araddr;
         rd_inh_nxt = latched_r && ctl_r[CTL_LAT];
      end
      awready_nxt = !aw_full_nxt && !bvalid_nxt;
      wready_nxt = !w_full_nxt && !bvalid_nxt;
      arready_nxt = !rd_pend_nxt && !rvalid_nxt;
      pump_on_nxt = ctl_nxt[CTL_PUMP] | ctl_nxt[CTL_PWR];
      hv_nxt = ctl_nxt[CTL_PWR];
      rc_on_nxt = ctl_nxt[CTL_RC] && !stop_s2_r;
   end

   always_ff @(posedge i_sys_clk) begin
      stop_s1_r <= i_stop_mode;
      stop_s2_r <= stop_s1_r;
      if (!i_nrst) begin
         aw_full_r <= 1'b0;
         aw_addr_r <= 12'h000;
         w_full_r <= 1'b0;
         w_data_r <= 8'h00;
         w_strb_r <= 1'b0;
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         arready_r <= 1'b0;
         rd_pend_r <= 1'b0;
         rd_addr_r <= 12'h000;
         rd_inh_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= 8'h00;
         rresp_r <= RESP_OKAY;
         ctl_r <= CTRL_RST;
         latched_r <= 1'b0;
         lat_addr_r <= 8'h00;
         lat_data_r <= 8'h00;
         done_r <= 1'b0;
         pump_on_r <= 1'b0;
         hv_r <= 1'b0;
         rc_on_r <= 1'b0;
      end else begin
         aw_full_r <= aw_full_nxt;
         aw_addr_r <= aw_addr_nxt;
         w_full_r <= w_full_nxt;
         w_data_r <= w_data_nxt;
         w_strb_r <= w_strb_nxt;
         awready_r <= awready_nxt;
         wready_r <= wready_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         arready_r <= arready_nxt;
         rd_pend_r <= rd_pend_nxt;
         rd_addr_r <= rd_addr_nxt;
         rd_inh_r <= rd_inh_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
         ctl_r <= ctl_nxt;
         latched_r <= latched_nxt;
         lat_addr_r <= lat_addr_nxt;
         lat_data_r <= lat_data_nxt;
         done_r <= done_nxt;
         pump_on_r <= pump_on_nxt;
         hv_r <= hv_nxt;
         rc_on_r <= rc_on_nxt;
      end
   end

   //*******************************************************
   // Program/erase engine
   //*******************************************************
   // Cells change only after the full pulse; a pulse cut short writes nothing
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      need_nxt = need_r;
      mode_nxt = mode_r;
      sw_addr_nxt = sw_addr_r;
      sw_last_nxt = sw_last_r;
      eng_done_nxt = 1'b0;
      mem_we = 1'b0;
      mem_waddr = sw_addr_r;
      mem_wdata = ERASED_BYTE;
      mem_raddr = (st_r == ENG_RDOLD) ? lat_addr_r : i_araddr[9:2];
      case (st_r)
         ENG_IDLE: begin
            if (ctl_r[CTL_PWR] && latched_r) begin
               st_nxt = ENG_PULSE;
               cnt_nxt = 32'h0;
               mode_nxt = epc_erase_t'({ctl_r[CTL_ERH], ctl_r[CTL_ERL]});
               case (epc_erase_t'({ctl_r[CTL_ERH], ctl_r[CTL_ERL]}))
                  EPC_ER_NONE: need_nxt = 32'(P_PGM_CYC);
                  EPC_ER_BYTE: need_nxt = 32'(P_BYTE_CYC);
                  EPC_ER_BLOCK: need_nxt = 32'(P_BLOCK_CYC);
                  default: need_nxt = 32'(P_BULK_CYC);
               endcase
            end
         end
         ENG_PULSE: begin
            if (!ctl_r[CTL_PWR]) begin
               st_nxt = ENG_IDLE;
            end else if (cnt_r == need_r - 32'h1) begin
               case (mode_r)
                  EPC_ER_NONE: st_nxt = ENG_RDOLD;
                  EPC_ER_BYTE: begin
                     sw_addr_nxt = lat_addr_r;
                     sw_last_nxt = lat_addr_r;
                  end
                  EPC_ER_BLOCK: begin
                     sw_addr_nxt = {lat_addr_r[7:6], 6'h00};
                     sw_last_nxt = {lat_addr_r[7:6], 6'h3F};
                  end
                  default: begin
                     sw_addr_nxt = 8'h00;
                     sw_last_nxt = 8'hFF;
                  end
               endcase
               if (mode_r != EPC_ER_NONE) begin
                  st_nxt = ENG_SWEEP;
               end
            end else begin
               cnt_nxt = cnt_r + 32'h1;
            end
         end
         ENG_RDOLD: st_nxt = ENG_PROG;
         ENG_PROG: begin
            mem_we = 1'b1;
            mem_waddr = lat_addr_r;
            mem_wdata = mem_q & lat_data_r;
            eng_done_nxt = 1'b1;
            st_nxt = ENG_HOLD;
         end
         ENG_SWEEP: begin
            mem_we = 1'b1;
            if (sw_addr_r == sw_last_r) begin
               eng_done_nxt = 1'b1;
               st_nxt = ENG_HOLD;
            end else begin
               sw_addr_nxt = sw_addr_r + 8'h01;
            end
         end
         ENG_HOLD: begin
            if (!ctl_r[CTL_PWR]) begin
               st_nxt = ENG_IDLE;
            end
         end
         default: st_nxt = ENG_IDLE;
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         st_r <= ENG_IDLE;
         cnt_r <= 32'h0;
         need_r <= 32'h0;
         mode_r <= EPC_ER_NONE;
         sw_addr_r <= 8'h00;
         sw_last_r <= 8'h00;
         eng_done_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         need_r <= need_nxt;
         mode_r <= mode_nxt;
         sw_addr_r <= sw_addr_nxt;
         sw_last_r <= sw_last_nxt;
         eng_done_r <= eng_done_nxt;
      end
   end

   assign o_awready = awready_r;
   assign o_wready = wready_r;
   assign o_bvalid = bvalid_r;
   assign o_bresp = bresp_r;
   assign o_arready = arready_r;
   assign o_rvalid = rvalid_r;
   assign o_rresp = rresp_r;
   assign o_rdata = {24'h000000, rdata_r};
   assign o_pump_on = pump_on_r;
   assign o_array_hv = hv_r;
   assign o_rc_osc_on = rc_on_r;

   //*******************************************************
   // Checks
   //*******************************************************
   sequence s_ctrl_write;
      aw_full_r && w_full_r && !bvalid_r && aw_addr_r == CTRL_OFS && w_strb_r;
   endsequence
   sequence s_pulse_end;
      st_r == ENG_PULSE && ctl_r[CTL_PWR] && cnt_r == need_r - 32'h1;
   endsequence

   a_reset_clears: assert property (@(posedge i_sys_clk) !i_nrst |=>
      ctl_r == CTRL_RST && st_r == ENG_IDLE && !latched_r)
      else $error("reset left control or engine active");
   a_power_gate: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      s_ctrl_write and (!ctl_r[CTL_LAT] && !ctl_r[CTL_PWR]) |=> !ctl_r[CTL_PWR])
      else $error("power bit set without latch");
   a_hv_pump: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      o_array_hv |-> o_pump_on)
      else $error("array power without pump");
   a_latch_capture: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      (aw_full_r && w_full_r && !bvalid_r && aw_addr_r[11:10] == ARR_SEL && w_strb_r
       && ctl_r[CTL_LAT] && ctl_nxt[CTL_LAT])
      |=> latched_r && lat_addr_r == $past(aw_addr_r[9:2]))
      else $error("array write not captured");
   a_read_inhibit: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      (i_arvalid && arready_r && i_araddr[11:10] == ARR_SEL && latched_r && ctl_r[CTL_LAT])
      |=> ##1 rvalid_r && rdata_r == INHIBIT_DATA)
      else $error("array read not inhibited");
   a_write_latched: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      mem_we |-> $past(ctl_r[CTL_PWR]) && st_r inside {ENG_PROG, ENG_SWEEP})
      else $error("array written outside a pulse");
   a_prog_ones_only: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      (mem_we && st_r == ENG_PROG) |-> (mem_wdata & ~mem_q) == 8'h00
      && $past(mem_raddr) == mem_waddr)
      else $error("programming raised a bit");
   a_block_range: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      (mem_we && mode_r == EPC_ER_BLOCK) |-> mem_waddr[7:6] == lat_addr_r[7:6])
      else $error("block erase left its block");
   a_byte_only: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      (mem_we && mode_r == EPC_ER_BYTE) |-> mem_waddr == lat_addr_r && st_r == ENG_SWEEP)
      else $error("byte erase hit another byte");
   a_erase_start: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      s_pulse_end and mode_r == EPC_ER_BULK |=> mem_we && mem_waddr == 8'h00)
      else $error("bulk erase did not start at zero");
   a_stop_rc: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      stop_s2_r |=> !o_rc_osc_on)
      else $error("rc oscillator on in stop");
endmodule : epc_ctrl

/* design/epc_pkg.sv */
/*
 * Constants, register map and timing for the EEPROM program/erase controller.
 * Assumes a 100 MHz system clock and an AXI4-Lite master with 32-bit data.
 */
package epc_pkg;

   //*******************************************************
   // Clock and timing
   //*******************************************************
   localparam int CLK_MHZ = 100;
   localparam int PGM_TIME_US = 10000;
   localparam int BYTE_ERASE_TIME_US = 10000;
   localparam int BLOCK_ERASE_TIME_US = 10000;
   localparam int BULK_ERASE_TIME_US = 10000;
   localparam int PGM_CYC = PGM_TIME_US * CLK_MHZ;
   localparam int BYTE_ERASE_CYC = BYTE_ERASE_TIME_US * CLK_MHZ;
   localparam int BLOCK_ERASE_CYC = BLOCK_ERASE_TIME_US * CLK_MHZ;
   localparam int BULK_ERASE_CYC = BULK_ERASE_TIME_US * CLK_MHZ;

   //*******************************************************
   // Array geometry
   //*******************************************************
   localparam int ARRAY_BYTES = 256;
   localparam int BLOCK_BYTES = 64;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [7:0] INHIBIT_DATA = 8'hFF;

   //*******************************************************
   // Register map (byte addresses)
   //*******************************************************
   localparam int ADDR_W = 12;
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] STAT_OFS = 12'h004;
   localparam logic [1:0] ARR_SEL = 2'h1;
   localparam logic [7:0] CTRL_RST = 8'h00;

   localparam int CTL_PWR = 0;
   localparam int CTL_LAT = 1;
   localparam int CTL_ERL = 2;
   localparam int CTL_ERH = 3;
   localparam int CTL_PUMP = 4;
   localparam int CTL_RC = 5;
   localparam logic [7:0] CTRL_MASK = 8'h3F;

   localparam int ST_LATCHED = 0;
   localparam int ST_BUSY = 1;
   localparam int ST_DONE = 2;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      EPC_ER_NONE = 2'h0,
      EPC_ER_BYTE = 2'h1,
      EPC_ER_BLOCK = 2'h2,
      EPC_ER_BULK = 2'h3
   } epc_erase_t;

endpackage : epc_pkg

/* design/epc_mem.sv */
/*
 * Byte array standing in for the EEPROM cells: one write port, one read port.
 * Assumes one clock; read data appear from a register one cycle after the address.
 */
`timescale 1ns/10ps
module epc_mem #(
   parameter int DATA_W = 8,
   parameter int DEPTH = 256,
   parameter int AW = $clog2(DEPTH)
) (
   input wire logic i_sys_clk,
   input wire logic i_we,
   input wire logic [AW-1:0] i_waddr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic [AW-1:0] i_raddr,
   output logic [DATA_W-1:0] o_rdata
);
   logic [DATA_W-1:0] mem_r [DEPTH];

   // Cells hold their contents across reset; they start erased
   initial begin
      for (int i = 0; i < DEPTH; i++) begin
         mem_r[i] = '1;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_we) begin
         mem_r[i_waddr] <= i_wdata;
      end
      o_rdata <= mem_r[i_raddr];
   end
endmodule : epc_mem

/* verif/epc_ctrl_tb.sv */
/* Self-checking bench for epc_ctrl: register, array and pulse traffic.
   Assumes only the controller, one 100 MHz clock and short pulse counts. */
`timescale 1ns/10ps
module epc_ctrl_tb import epc_pkg::*;;
   localparam int PC = 10;
   localparam int YC = 12;
   localparam int KC = 14;
   localparam int UC = 16;
   localparam logic [11:0] ARR = 12'h400;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic stop = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hF;
   logic awready, wready, bvalid, arready, rvalid, pump, hv, rc;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   int n_fail = 0;
   int n_tests = 0;

   always #5 clk = ~clk;

   epc_ctrl #(.P_PGM_CYC(PC), .P_BYTE_CYC(YC), .P_BLOCK_CYC(KC), .P_BULK_CYC(UC)) u_dut (
      .i_sys_clk(clk), .i_nrst(nrst), .i_awaddr(awaddr), .i_awvalid(awvalid),
      .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
      .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
      .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
      .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_stop_mode(stop),
      .o_pump_on(pump), .o_array_hv(hv), .o_rc_osc_on(rc));

   //*****************************
   // Checking and bus tasks
   //*****************************
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", s, e, g);
      end
   endtask : chk

   function automatic logic [11:0] aa(input int i);
      return ARR + 12'(i * 4);
   endfunction : aa

   // Address and data may be taken on different edges
   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
      bit ad, wd;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge clk);
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge clk);
         if (awvalid && awready) begin
            ad = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            wd = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, bresp});
   endtask : wr

   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd

   task automatic rc_(input string s, input logic [11:0] a, input logic [7:0] e,
                      input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk(s, {24'h0, e}, d);
      chk("rresp", {30'h0, er}, {30'h0, r});
   endtask : rc_

   // One whole program or erase sequence; mode holds the erase field bits
   task automatic op(input logic [7:0] mode, input int i, input logic [7:0] d);
      logic [31:0] s;
      logic [1:0] r;
      wr(CTRL_OFS, mode | 8'h12, RESP_OKAY);
      wr(aa(i), d, RESP_OKAY);
      rc_("inhibited read", aa(i), 8'hFF, RESP_OKAY);
      rc_("status captured", STAT_OFS, 8'h01, RESP_OKAY);
      wr(CTRL_OFS, mode | 8'h13, RESP_OKAY);
      chk("array power", 32'h1, {31'h0, hv});
      chk("pump", 32'h1, {31'h0, pump});
      do rd(STAT_OFS, s, r); while (s[ST_DONE] !== 1'b1);
      chk("status done", 32'h07, s);
      wr(CTRL_OFS, mode | 8'h12, RESP_OKAY);
      repeat (2) @(posedge clk);
      chk("power off", 32'h0, {31'h0, hv});
      wr(STAT_OFS, 8'h04, RESP_OKAY);
      rc_("status cleared", STAT_OFS, 8'h01, RESP_OKAY);
      wr(CTRL_OFS, 8'h00, RESP_OKAY);
   endtask : op

   //*****************************
   // Scenarios
   //*****************************
   task automatic t_reset;
      rc_("ctrl reset", CTRL_OFS, 8'h00, RESP_OKAY);
      chk("pump reset", 32'h0, {31'h0, pump});
      chk("rc reset", 32'h0, {31'h0, rc});
      rc_("unmapped", 12'h100, 8'h00, RESP_SLVERR);
      wr(12'h100, 8'h3F, RESP_SLVERR);
      $display("test reset done");
   endtask : t_reset

   task automatic t_fields;
      wr(CTRL_OFS, 8'h11, RESP_OKAY);
      rc_("power locked", CTRL_OFS, 8'h10, RESP_OKAY);
      chk("no power", 32'h0, {31'h0, hv});
      for (int m = 0; m < 4; m++) begin
         wr(CTRL_OFS, 8'(m << 2), RESP_OKAY);
         rc_("erase field", CTRL_OFS, 8'(m << 2), RESP_OKAY);
      end
      wr(CTRL_OFS, 8'h00, RESP_OKAY);
      $display("test fields done");
   endtask : t_fields

   task automatic t_program;
      op(8'h0C, 9, 8'h00);
      rc_("bulk lo", aa(0), 8'hFF, RESP_OKAY);
      rc_("bulk hi", aa(255), 8'hFF, RESP_OKAY);
      op(8'h00, 3, 8'hA5);
      rc_("program", aa(3), 8'hA5, RESP_OKAY);
      op(8'h00, 3, 8'h5A);
      rc_("ones to zeros", aa(3), 8'h00, RESP_OKAY);
      wr(aa(3), 8'hFF, RESP_OKAY);
      rc_("plain write", aa(3), 8'h00, RESP_OKAY);
      $display("test program done");
   endtask : t_program

   task automatic t_erase;
      op(8'h00, 64, 8'h00);
      op(8'h00, 130, 8'h00);
      op(8'h08, 100, 8'h00);
      rc_("block erased", aa(64), 8'hFF, RESP_OKAY);
      rc_("block kept", aa(130), 8'h00, RESP_OKAY);
      op(8'h04, 130, 8'h00);
      rc_("byte erased", aa(130), 8'hFF, RESP_OKAY);
      rc_("byte kept", aa(3), 8'h00, RESP_OKAY);
      $display("test erase done");
   endtask : t_erase

   task automatic t_abort;
      // Power dropped well before the pulse count ends: no cell may change
      wr(CTRL_OFS, 8'h12, RESP_OKAY);
      wr(aa(6), 8'h00, RESP_OKAY);
      wr(CTRL_OFS, 8'h13, RESP_OKAY);
      wr(CTRL_OFS, 8'h12, RESP_OKAY);
      rc_("status short pulse", STAT_OFS, 8'h01, RESP_OKAY);
      wr(CTRL_OFS, 8'h00, RESP_OKAY);
      rc_("short pulse kept", aa(6), 8'hFF, RESP_OKAY);
      wr(CTRL_OFS, 8'h12, RESP_OKAY);
      wr(aa(5), 8'h00, RESP_OKAY);
      wr(CTRL_OFS, 8'h13, RESP_OKAY);
      repeat (3) @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk("abort power", 32'h0, {31'h0, hv});
      nrst <= 1'b1;
      repeat (2) @(posedge clk);
      rc_("ctrl after abort", CTRL_OFS, 8'h00, RESP_OKAY);
      rc_("status after abort", STAT_OFS, 8'h00, RESP_OKAY);
      $display("test abort done");
   endtask : t_abort

   task automatic t_rc;
      wr(CTRL_OFS, 8'h20, RESP_OKAY);
      repeat (3) @(posedge clk);
      chk("rc on", 32'h1, {31'h0, rc});
      stop <= 1'b1;
      repeat (5) @(posedge clk);
      chk("rc stop", 32'h0, {31'h0, rc});
      rc_("rc kept", CTRL_OFS, 8'h20, RESP_OKAY);
      stop <= 1'b0;
      wr(CTRL_OFS, 8'h00, RESP_OKAY);
      $display("test rc done");
   endtask : t_rc

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : test_done

   // Whole run is about a thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      test_done();
   end

   initial begin
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      repeat (2) @(posedge clk);
      t_reset();
      t_fields();
      t_program();
      t_erase();
      t_abort();
      t_rc();
      test_done();
   end
endmodule : epc_ctrl_tb
